/* hdl/seq_params.svh */
// Constants for the program sequencer and table read block.
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define CLK_PER_NS 8
`define SYS_PER_12_NS 83
`define SYS_PER_6_NS 167
`define REG_PC_LOW 8'h06
`define REG_TAB_PTR_LOW 8'h07
`define REG_TAB_HIGH 8'h08
`define REG_WDT_PRESCALE 8'h09
`define REG_SYS_CLK_CTRL 8'h1C
`define REG_TAB_PAGE 8'h1F
`define SCC_SEL_BIT 0
`define SCC_RESET 8'h01
`define VEC_RESET 11'h000
`define VEC_USB 11'h004
`define VEC_TMR 11'h00C
`define LAST_PAGE 3'h7
`define PHASE_LAST 2'h3
`define SST_TICKS 1024
`define WDT_BASE_RC 17'h0_0400
`define PC_ONE 11'h001
`endif

/* hdl/seq_pkg.sv */
// Types shared by the program sequencer and its environment.
`default_nettype none
package seq_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SKIP = 3'b001,
    OP_JUMP = 3'b010,
    OP_CALL = 3'b011,
    OP_RET = 3'b100,
    OP_TAB_CUR = 3'b101,
    OP_TAB_LAST = 3'b110
  } seq_op_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_START = 2'b10
  } run_state_e;
  typedef struct packed {
    seq_op_e op;
    logic [10:0] target;
    logic [6:0] dest;
  } seq_cmd_s;
  typedef struct packed {
    logic wr;
    logic [6:0] dest;
    logic [7:0] data;
  } tab_res_s;
endpackage
`default_nettype wire

/* hdl/program_sequencer.sv */
// Program sequencer: clock phases, fetch pipeline, program counter and table reads.
//
// Contract
// RULE1: System clock is 6 or 12 MHz by a select bit, 12 MHz after reset.
// RULE2: Each instruction cycle is four system clock phases.
// RULE3: Fetch overlaps execute; instructions changing the PC take two cycles.
// RULE4: The PC steps by one after every instruction fetch.
// RULE5: A taken skip discards the prefetched word, giving PC+2.
// RULE6: Writing the PC low byte jumps within the current 256-word page.
// RULE7: Jump, call, return and vectors load all 11 PC bits.
// RULE8: Reset clears the PC to address zero.
// RULE9: Enabled USB request with stack room vectors to 004H.
// RULE10: Enabled timer overflow with stack room vectors to 00CH.
// RULE11: Program memory is 2048 words of 14 bits, read by PC and table.
// RULE12: A table read stores the low byte to data memory, upper bits to high byte.
// RULE13: Current-page table read without page option uses PC bits 10 to 8.
// RULE14: With page option, bits 10 to 8 come from page pointer bits 2 to 0.
// RULE15: Last-page table read forces address bits 10 to 8 to ones.
// RULE16: Table upper bits sit low in the high byte; the rest read zero.
// RULE17: The high byte is read only; both table pointers are read and write.
// RULE18: Every table read takes two instruction cycles.
// RULE19: Firmware masks interrupts around main-program table reads.
// RULE20: Wake from halt waits 1024 system clock periods before running.
// RULE21: Watchdog time-out is prescale times 256 plus 1024 RC periods.
// RULE22: Reading the PC low byte returns PC bits 7 to 0.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "seq_params.svh"
module program_sequencer #(
  parameter int PM_AW = 11,
  parameter int PM_DW = 14,
  parameter bit PAGE_PTR_EN = 1'b0,
  parameter int SST_TICKS = `SST_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r,
  output logic [PM_AW-1:0] pm_addr_r,
  input wire logic [PM_DW-1:0] pm_rdata,
  output logic [PM_DW-1:0] ir_r,
  output logic ir_valid_r,
  input wire seq_pkg::seq_cmd_s cmd,
  input wire logic [PM_AW-1:0] stack_top,
  input wire logic stack_full,
  output logic stack_push_r,
  output logic stack_pop_r,
  output logic [PM_AW-1:0] push_addr_r,
  input wire logic int_enable,
  input wire logic usb_irq,
  input wire logic tmr_irq,
  output logic [1:0] irq_ack_r,
  output seq_pkg::tab_res_s tab_res_r,
  input wire logic halt_req,
  input wire logic wake,
  output seq_pkg::run_state_e run_state_r,
  output logic [1:0] phase_r,
  output logic sys_clock_freq_select_r,
  input wire logic rc_clk_pin,
  input wire logic wdt_clear,
  output logic wdt_timeout_r
);
  import seq_pkg::*;

  localparam logic [4:0] DIV12 = 5'(`SYS_PER_12_NS / `CLK_PER_NS - 1);
  localparam logic [4:0] DIV6 = 5'(`SYS_PER_6_NS / `CLK_PER_NS - 1);
  localparam logic [10:0] SST_LAST = 11'(SST_TICKS - 1);

  logic [4:0] div_cnt_r;
  logic [10:0] sst_cnt_r;
  logic [PM_AW-1:0] pc_r, tab_addr, pcl_addr;
  logic [6:0] tab_dest_r;
  logic [7:0] pcl_val_r, table_pointer_low_r, table_page_pointer_r, table_high_byte_r;
  logic [7:0] watchdog_prescale_setting_r, system_clock_control_r;
  logic [16:0] wdt_cnt_r, wdt_limit;
  logic sys_tick_r, tab_pend_r, pcl_pend_r, rc_s1_r, rc_s2_r, rc_s3_r;
  logic cyc_end, exec, irq_ok, usb_go, tmr_go;

  // The phase divider runs even while halted so that wake-up timing stays exact.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_r <= 5'h00;
      sys_tick_r <= 1'b0;
    end else if (div_cnt_r == (sys_clock_freq_select_r ? DIV12 : DIV6)) begin // RULE1
      div_cnt_r <= 5'h00;
      sys_tick_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 5'h01;
      sys_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_r <= 2'h0;
    end else if (sys_tick_r) begin
      phase_r <= phase_r + 2'h1; // RULE2
    end
  end

  assign cyc_end = sys_tick_r && (phase_r == `PHASE_LAST) && (run_state_r == ST_RUN);
  assign exec = cyc_end && ir_valid_r && !tab_pend_r && !pcl_pend_r;
  assign irq_ok = exec && (cmd.op == OP_NONE) && int_enable && !stack_full;
  assign usb_go = irq_ok && usb_irq; // RULE9
  assign tmr_go = irq_ok && !usb_irq && tmr_irq; // RULE10
  assign pcl_addr = {pc_r[10:8], pcl_val_r}; // RULE6

  always_comb begin
    if (cmd.op == OP_TAB_LAST) begin
      tab_addr = {`LAST_PAGE, table_pointer_low_r}; // RULE15
    end else if (PAGE_PTR_EN) begin
      tab_addr = {table_page_pointer_r[2:0], table_pointer_low_r}; // RULE14
    end else begin
      tab_addr = {pc_r[10:8], table_pointer_low_r}; // RULE13
    end
  end

  // Halt, wake and start-up delay.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_state_r <= ST_RUN;
      sst_cnt_r <= 11'h000;
    end else begin
      case (run_state_r)
        ST_RUN: begin
          if (halt_req) begin
            run_state_r <= ST_HALT;
          end
        end
        ST_HALT: begin
          sst_cnt_r <= 11'h000;
          if (wake) begin
            run_state_r <= ST_START;
          end
        end
        ST_START: begin
          if (sys_tick_r) begin
            if (sst_cnt_r == SST_LAST) begin
              run_state_r <= ST_RUN; // RULE20
            end else begin
              sst_cnt_r <= sst_cnt_r + 11'h001;
            end
          end
        end
        default: begin
          run_state_r <= ST_RUN;
        end
      endcase
    end
  end

  // Fetch pipeline: pm_addr_r is the word being fetched, ir_r the one executing.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_r <= `VEC_RESET; // RULE8
      pm_addr_r <= `VEC_RESET;
      ir_r <= '0;
      ir_valid_r <= 1'b0;
      tab_pend_r <= 1'b0;
      tab_dest_r <= 7'h00;
    end else if (cyc_end) begin
      if (!tab_pend_r) begin
        ir_r <= pm_rdata; // RULE3
      end
      if (tab_pend_r) begin
        pm_addr_r <= pc_r;
        pc_r <= pc_r + `PC_ONE;
        ir_valid_r <= 1'b1; // RULE18
        tab_pend_r <= 1'b0;
      end else if (pcl_pend_r) begin
        pm_addr_r <= pcl_addr; // RULE6
        pc_r <= pcl_addr + `PC_ONE;
        ir_valid_r <= 1'b0;
      end else if (usb_go) begin
        pm_addr_r <= `VEC_USB; // RULE9
        pc_r <= `VEC_USB + `PC_ONE;
        ir_valid_r <= 1'b0;
      end else if (tmr_go) begin
        pm_addr_r <= `VEC_TMR; // RULE10
        pc_r <= `VEC_TMR + `PC_ONE;
        ir_valid_r <= 1'b0;
      end else if (exec && (cmd.op == OP_JUMP || cmd.op == OP_CALL)) begin
        pm_addr_r <= cmd.target; // RULE7
        pc_r <= cmd.target + `PC_ONE;
        ir_valid_r <= 1'b0; // RULE3
      end else if (exec && cmd.op == OP_RET) begin
        pm_addr_r <= stack_top; // RULE7
        pc_r <= stack_top + `PC_ONE;
        ir_valid_r <= 1'b0;
      end else if (exec && cmd.op == OP_SKIP) begin
        pm_addr_r <= pc_r;
        pc_r <= pc_r + `PC_ONE;
        ir_valid_r <= 1'b0; // RULE5
      end else if (exec && (cmd.op == OP_TAB_CUR || cmd.op == OP_TAB_LAST)) begin
        // The prefetched word is parked in ir_r while the port serves the table.
        pm_addr_r <= tab_addr; // RULE11
        ir_valid_r <= 1'b0;
        tab_pend_r <= 1'b1; // RULE18
        tab_dest_r <= cmd.dest;
      end else begin
        pm_addr_r <= pc_r;
        pc_r <= pc_r + `PC_ONE; // RULE4
        ir_valid_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_push_r <= 1'b0;
      stack_pop_r <= 1'b0;
      push_addr_r <= '0;
      irq_ack_r <= 2'b00;
    end else begin
      stack_push_r <= usb_go || tmr_go || (exec && !pcl_pend_r && cmd.op == OP_CALL);
      stack_pop_r <= exec && cmd.op == OP_RET;
      irq_ack_r <= {tmr_go, usb_go};
      if (cyc_end) begin
        push_addr_r <= pm_addr_r;
      end
    end
  end

  // Table result: low byte to data memory, remaining bits into the high byte.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tab_res_r <= '0;
      table_high_byte_r <= 8'h00;
    end else if (cyc_end && tab_pend_r) begin
      tab_res_r.wr <= 1'b1; // RULE12
      tab_res_r.dest <= tab_dest_r;
      tab_res_r.data <= pm_rdata[7:0];
      table_high_byte_r <= 8'(pm_rdata[PM_DW-1:8]); // RULE16
    end else begin
      tab_res_r.wr <= 1'b0;
    end
  end

  // A short jump written over the bus waits for the next cycle boundary with no table read pending.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pcl_pend_r <= 1'b0;
      pcl_val_r <= 8'h00;
    end else if (reg_wr && reg_addr == `REG_PC_LOW) begin
      pcl_pend_r <= 1'b1;
      pcl_val_r <= reg_wdata;
    end else if (cyc_end && !tab_pend_r) begin
      pcl_pend_r <= 1'b0;
    end
  end

  // The high byte has no write path, so software cannot restore it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      table_pointer_low_r <= 8'h00;
      table_page_pointer_r <= 8'h00;
      watchdog_prescale_setting_r <= 8'h00;
      system_clock_control_r <= `SCC_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `REG_TAB_PTR_LOW) begin
        table_pointer_low_r <= reg_wdata; // RULE17
      end else if (reg_addr == `REG_TAB_PAGE) begin
        table_page_pointer_r <= reg_wdata; // RULE17
      end else if (reg_addr == `REG_WDT_PRESCALE) begin
        watchdog_prescale_setting_r <= reg_wdata;
      end else if (reg_addr == `REG_SYS_CLK_CTRL) begin
        system_clock_control_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_clock_freq_select_r <= 1'(`SCC_RESET >> `SCC_SEL_BIT);
    end else begin
      sys_clock_freq_select_r <= system_clock_control_r[`SCC_SEL_BIT]; // RULE1
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `REG_PC_LOW) begin
        reg_rdata_r <= pc_r[7:0]; // RULE22
      end else if (reg_addr == `REG_TAB_PTR_LOW) begin
        reg_rdata_r <= table_pointer_low_r;
      end else if (reg_addr == `REG_TAB_HIGH) begin
        reg_rdata_r <= table_high_byte_r; // RULE17
      end else if (reg_addr == `REG_WDT_PRESCALE) begin
        reg_rdata_r <= watchdog_prescale_setting_r;
      end else if (reg_addr == `REG_SYS_CLK_CTRL) begin
        reg_rdata_r <= system_clock_control_r;
      end else if (reg_addr == `REG_TAB_PAGE) begin
        reg_rdata_r <= table_page_pointer_r;
      end else begin
        reg_rdata_r <= 8'h00;
      end
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  // The RC clock is asynchronous, so only its synchronised copy is edge detected.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      rc_s1_r <= rc_clk_pin;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end

  assign wdt_limit = {1'b0, watchdog_prescale_setting_r, 8'h00} + `WDT_BASE_RC; // RULE21

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdt_cnt_r <= 17'h0_0000;
      wdt_timeout_r <= 1'b0;
    end else if (wdt_clear) begin
      wdt_cnt_r <= 17'h0_0000;
      wdt_timeout_r <= 1'b0;
    end else if (rc_s2_r && !rc_s3_r) begin
      if (wdt_cnt_r + 17'h0_0001 >= wdt_limit) begin
        wdt_cnt_r <= 17'h0_0000;
        wdt_timeout_r <= 1'b1; // RULE21
      end else begin
        wdt_cnt_r <= wdt_cnt_r + 17'h0_0001;
        wdt_timeout_r <= 1'b0;
      end
    end else begin
      wdt_timeout_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_tab_go;
    exec && !usb_go && !tmr_go && (cmd.op == OP_TAB_CUR || cmd.op == OP_TAB_LAST);
  endsequence
  sequence s_tab_done;
    ##[1:80] (cyc_end && tab_pend_r) ##1 tab_res_r.wr;
  endsequence

  property p_phase_wrap;
    sys_tick_r && phase_r == 2'h3 |=> phase_r == 2'h0 && !sys_tick_r;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap"); // RULE2
  property p_fetch_inc;
    cyc_end && !tab_pend_r && !pcl_pend_r && (!ir_valid_r || cmd.op == OP_NONE) && !irq_ok
      |=> pc_r == $past(pc_r) + 11'h001 && pm_addr_r == $past(pc_r);
  endproperty
  a_fetch_inc: assert property (p_fetch_inc) else $error("pc did not step"); // RULE4
  property p_skip;
    exec && cmd.op == OP_SKIP |=> !ir_valid_r && pc_r == $past(pc_r) + 11'h001;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not discarded"); // RULE5
  property p_jump;
    exec && cmd.op == OP_JUMP |=> pm_addr_r == $past(cmd.target) && !ir_valid_r;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong"); // RULE7
  property p_pcl;
    cyc_end && pcl_pend_r && !tab_pend_r
      |=> pm_addr_r == {$past(pc_r[10:8]), $past(pcl_val_r)} && !ir_valid_r;
  endproperty
  a_pcl: assert property (p_pcl) else $error("short jump wrong"); // RULE6
  property p_reset;
    disable iff (1'b0) !rst_n |=> pc_r == 11'h000 && pm_addr_r == 11'h000;
  endproperty
  a_reset: assert property (p_reset) else $error("pc not cleared"); // RULE8
  property p_usb_vec;
    usb_go |=> pm_addr_r == 11'h004 && stack_push_r && irq_ack_r == 2'b01 ##1 irq_ack_r == 2'b00;
  endproperty
  a_usb_vec: assert property (p_usb_vec) else $error("usb vector wrong"); // RULE9
  property p_tmr_vec;
    tmr_go |=> pm_addr_r == 11'h00C && irq_ack_r == 2'b10;
  endproperty
  a_tmr_vec: assert property (p_tmr_vec) else $error("timer vector wrong"); // RULE10
  property p_tab_last;
    s_tab_go and (cmd.op == OP_TAB_LAST) |=> pm_addr_r[10:8] == 3'b111;
  endproperty
  a_tab_last: assert property (p_tab_last) else $error("last page wrong"); // RULE15
  property p_tab_two;
    s_tab_go |-> s_tab_done;
  endproperty
  a_tab_two: assert property (p_tab_two) else $error("table read late"); // RULE18
  property p_tab_high;
    tab_res_r.wr |-> table_high_byte_r == 8'($past(pm_rdata[PM_DW-1:8]))
      && tab_res_r.data == $past(pm_rdata[7:0]) && !tab_pend_r;
  endproperty
  a_tab_high: assert property (p_tab_high) else $error("high byte bits set"); // RULE16
endmodule
`default_nettype wire

/* verification/prog_mem_model.sv */
// Program memory model that answers the sequencer's fetch and table addresses.
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
  input wire logic clk,
  input wire logic [10:0] addr,
  output logic [13:0] rdata
);
  // Every word carries its own address, so a wrong fetch or table address shows at once.
  // One clock of latency, far inside the time the sequencer allows.
  always_ff @(posedge clk) begin
    rdata <= {3'b101, addr};
  end
endmodule
`default_nettype wire

/* verification/program_sequencer_tb_top.sv */
// Self-checking bench for the program sequencer and its table reads.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module program_sequencer_table_read_tb_top;
  import seq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_r;
  logic [10:0] pm_addr_r;
  logic [13:0] pm_rdata;
  logic [13:0] ir_r;
  logic ir_valid_r;
  seq_cmd_s cmd = '{OP_NONE, 11'h000, 7'h00};
  logic [10:0] stack_top = 11'h2bc;
  logic stack_full = 1'b0;
  logic stack_push_r;
  logic stack_pop_r;
  logic [10:0] push_addr_r;
  // Interrupts stay masked while table reads run.
  logic int_enable = 1'b0;
  logic usb_irq = 1'b0;
  logic tmr_irq = 1'b0;
  logic [1:0] irq_ack_r;
  tab_res_s tab_res_r;
  logic halt_req = 1'b0;
  logic wake = 1'b0;
  run_state_e run_state_r;
  logic [1:0] phase_r;
  logic sys_clock_freq_select_r;
  logic rc_clk_pin = 1'b0;
  logic wdt_clear = 1'b1;
  logic wdt_timeout_r;
  int fail_count = 0;
  int n_compared = 0;
  int n;
  int i;
  logic [7:0] d;
  logic [10:0] a;
  logic push_s;
  logic pop_s;
  logic ivs;
  logic [1:0] ack_s;
  logic [15:0] tab_got = 16'h0000;
  logic wdt_seen = 1'b0;
  logic [10:0] pm_addr_page;
  logic [13:0] pm_rdata_page;

  always #4 clk = ~clk;

  program_sequencer #(.SST_TICKS(4)) program_sequencer_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .pm_addr_r(pm_addr_r), .pm_rdata(pm_rdata),
    .ir_r(ir_r), .ir_valid_r(ir_valid_r), .cmd(cmd), .stack_top(stack_top),
    .stack_full(stack_full), .stack_push_r(stack_push_r), .stack_pop_r(stack_pop_r),
    .push_addr_r(push_addr_r), .int_enable(int_enable), .usb_irq(usb_irq), .tmr_irq(tmr_irq),
    .irq_ack_r(irq_ack_r), .tab_res_r(tab_res_r), .halt_req(halt_req), .wake(wake),
    .run_state_r(run_state_r), .phase_r(phase_r),
    .sys_clock_freq_select_r(sys_clock_freq_select_r), .rc_clk_pin(rc_clk_pin),
    .wdt_clear(wdt_clear), .wdt_timeout_r(wdt_timeout_r)
  );
  prog_mem_model prog_mem_model_inst (.clk(clk), .addr(pm_addr_r), .rdata(pm_rdata));

  // A twin with the page pointer option runs in lockstep; only its table address differs.
  program_sequencer #(.PAGE_PTR_EN(1'b1), .SST_TICKS(4)) program_sequencer_page_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(), .pm_addr_r(pm_addr_page), .pm_rdata(pm_rdata_page),
    .ir_r(), .ir_valid_r(), .cmd(cmd), .stack_top(stack_top),
    .stack_full(stack_full), .stack_push_r(), .stack_pop_r(),
    .push_addr_r(), .int_enable(int_enable), .usb_irq(usb_irq), .tmr_irq(tmr_irq),
    .irq_ack_r(), .tab_res_r(), .halt_req(halt_req), .wake(wake),
    .run_state_r(), .phase_r(),
    .sys_clock_freq_select_r(), .rc_clk_pin(rc_clk_pin),
    .wdt_clear(wdt_clear), .wdt_timeout_r()
  );
  prog_mem_model prog_mem_model_page_inst (
    .clk(clk), .addr(pm_addr_page), .rdata(pm_rdata_page)
  );

  // Pulses are latched here so that a poll between edges cannot miss them.
  always @(posedge clk) begin
    if (tab_res_r.wr === 1'b1) tab_got <= tab_res_r;
    if (wdt_timeout_r === 1'b1) wdt_seen <= 1'b1;
  end

  function automatic logic [13:0] word(input logic [10:0] x);
    return {3'b101, x};
  endfunction

  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] ad, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_r;
  endtask

  // Waits for the fetch address to move, which marks an instruction-cycle end.
  task automatic wait_end(output int cnt);
    logic [10:0] p;
    p = pm_addr_r;
    cnt = 0;
    while (pm_addr_r === p) begin
      @(posedge clk);
      #1 cnt++;
      if (cnt > 400) begin
        fail_count++;
        end_of_test();
      end
    end
    push_s = stack_push_r;
    pop_s = stack_pop_r;
    ack_s = irq_ack_r;
    ivs = ir_valid_r;
  endtask

  // Offers one decoder answer for a real instruction, right after a cycle end.
  task automatic do_op(input seq_op_e op, input logic [10:0] t, input logic [6:0] ds);
    wait_end(n);
    if (ir_valid_r !== 1'b1) wait_end(n);
    @(posedge clk);
    cmd <= '{op, t, ds};
    wait_end(n);
    @(posedge clk);
    cmd <= '{OP_NONE, 11'h000, 7'h00};
  endtask

  task automatic wait_state(input run_state_e s);
    for (i = 0; i < 2000 && run_state_r !== s; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 2000) begin
      fail_count++;
      end_of_test();
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 `CHK("pc_reset", 11'h000, pm_addr_r)
    `CHK("clk_sel_reset", 1'b1, sys_clock_freq_select_r)
    rd_reg(8'h1c, d);
    `CHK("clk_ctrl", 8'h01, d)
    wait_end(n);
    wait_end(n);
    `CHK("cycle_len_12", 40, n)
    `CHK("phase_start", 2'h0, phase_r)
    a = pm_addr_r;
    wait_end(n);
    `CHK("pc_step", a + 11'h001, pm_addr_r)
    rd_reg(8'h06, d);
    `CHK("pc_low_read", 8'(a + 11'h002), d)
    wr_reg(8'h07, 8'h5a);
    wr_reg(8'h1f, 8'h06);
    rd_reg(8'h07, d);
    `CHK("tab_ptr_low", 8'h5a, d)
    rd_reg(8'h1f, d);
    `CHK("tab_page", 8'h06, d)
    rd_reg(8'h0c, d);
    `CHK("unmapped", 8'h00, d)
    do_op(OP_TAB_LAST, 11'h000, 7'h21);
    `CHK("tab_addr_last", 11'h75a, pm_addr_r)
    `CHK("tab_dummy", 1'b0, ivs)
    wait_end(n);
    repeat (3) @(posedge clk);
    `CHK("tab_res_last", {1'b1, 7'h21, 8'h5a}, tab_got)
    rd_reg(8'h08, d);
    `CHK("tab_high_last", 8'h2f, d)
    wr_reg(8'h08, 8'hff);
    rd_reg(8'h08, d);
    `CHK("tab_high_ro", 8'h2f, d)
    do_op(OP_JUMP, 11'h3a5, 7'h00);
    `CHK("jump_addr", 11'h3a5, pm_addr_r)
    `CHK("jump_dummy", 1'b0, ivs)
    wait_end(n);
    `CHK("jump_ir", word(11'h3a5), ir_r)
    `CHK("jump_ir_valid", 1'b1, ir_valid_r)
    do_op(OP_TAB_CUR, 11'h000, 7'h22);
    `CHK("tab_addr_cur", 11'h35a, pm_addr_r)
    `CHK("tab_addr_page", 11'h65a, pm_addr_page)
    wait_end(n);
    repeat (3) @(posedge clk);
    `CHK("tab_res_cur", {1'b1, 7'h22, 8'h5a}, tab_got)
    rd_reg(8'h08, d);
    `CHK("tab_high_cur", 8'h2b, d)
    wr_reg(8'h06, 8'h40);
    wait_end(n);
    `CHK("pcl_jump", 11'h340, pm_addr_r)
    do_op(OP_CALL, 11'h123, 7'h00);
    `CHK("call_addr", 11'h123, pm_addr_r)
    `CHK("call_push", 1'b1, push_s)
    `CHK("call_ret_addr", 11'h341, push_addr_r)
    do_op(OP_RET, 11'h000, 7'h00);
    `CHK("ret_addr", 11'h2bc, pm_addr_r)
    `CHK("ret_pop", 1'b1, pop_s)
    do_op(OP_SKIP, 11'h000, 7'h00);
    `CHK("skip_dummy", 1'b0, ivs)
    a = pm_addr_r;
    wait_end(n);
    `CHK("skip_ir", word(a), ir_r)
    @(posedge clk);
    int_enable <= 1'b1;
    usb_irq <= 1'b1;
    tmr_irq <= 1'b1;
    for (int k = 0; k < 4 && pm_addr_r !== 11'h004; k++) wait_end(n);
    `CHK("usb_vector", 11'h004, pm_addr_r)
    `CHK("usb_ack", 2'b01, ack_s)
    @(posedge clk);
    usb_irq <= 1'b0;
    stack_full <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wait_end(n);
      `CHK("ack_blocked", 2'b00, ack_s)
    end
    @(posedge clk);
    stack_full <= 1'b0;
    for (int k = 0; k < 4 && pm_addr_r !== 11'h00c; k++) wait_end(n);
    `CHK("tmr_vector", 11'h00c, pm_addr_r)
    `CHK("tmr_ack", 2'b10, ack_s)
    @(posedge clk);
    tmr_irq <= 1'b0;
    int_enable <= 1'b0;
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    wait_state(ST_HALT);
    @(posedge clk);
    wake <= 1'b1;
    wait_state(ST_START);
    @(posedge clk);
    wake <= 1'b0;
    wait_state(ST_RUN);
    `CHK("start_wait", 1'b1, (i >= 30 && i <= 39))
    wr_reg(8'h1c, 8'h00);
    wait_end(n);
    wait_end(n);
    wait_end(n);
    `CHK("clk_sel_6", 1'b0, sys_clock_freq_select_r)
    `CHK("cycle_len_6", 80, n)
    wr_reg(8'h1c, 8'h01);
    wr_reg(8'h09, 8'h01);
    @(posedge clk);
    wdt_clear <= 1'b0;
    for (n = 0; n < 3000 && wdt_seen !== 1'b1; n++) begin
      repeat (2) @(posedge clk);
      rc_clk_pin <= 1'b1;
      repeat (2) @(posedge clk);
      rc_clk_pin <= 1'b0;
    end
    `CHK("wdt_edges", 1'b1, (n >= 1279 && n <= 1282))
    end_of_test();
  end
endmodule
`default_nettype wire
